// [design/host_read_buffer.sv]
`default_nettype none

// Small store for bytes read back from the device, registered read port
module host_read_buffer #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 3
) (
    input wire logic clk_in,                  // System clock
    input wire logic clk_en_in,               // Freezes the store while low
    input wire logic wr_en_in,                // Write strobe
    input wire logic [ADDR_W-1:0] wr_addr_in, // Write index
    input wire logic [DATA_W-1:0] wr_data_in, // Write data
    input wire logic [ADDR_W-1:0] rd_addr_in, // Read index
    output logic [DATA_W-1:0] rd_data_out     // Registered read data
);
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    // Plain storage, no reset needed on the array itself
    always_ff @(posedge clk_in) begin
        if (clk_en_in && wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // Read data from a flop so the output never glitches
    always_ff @(posedge clk_in) begin
        if (clk_en_in) begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end
endmodule

`default_nettype wire

// [design/i2c_host_command_port.sv]
`default_nettype none

package i2c_host_pkg;
    // Clock and bus rates
    localparam int SYS_CLK_KHZ = 100000;
    localparam int FAST_KBPS = 400;
    localparam int STD_KBPS = 100;
    // A bit is four quarters; least quarter rounds up
    localparam logic [8:0] QTR_FAST_CYC =
        9'((SYS_CLK_KHZ + 4 * FAST_KBPS - 1) / (4 * FAST_KBPS));
    localparam logic [8:0] QTR_STD_CYC =
        9'((SYS_CLK_KHZ + 4 * STD_KBPS - 1) / (4 * STD_KBPS));
    // Quarter positions inside one bit
    localparam logic [1:0] Q_FALL = 2'h0;
    localparam logic [1:0] Q_DATA = 2'h1;
    localparam logic [1:0] Q_RISE = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;
    // Bit index of the acknowledge slot
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Direction bit values
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    // Command codes
    localparam logic [7:0] CMD_CHIP_RESET = 8'hf0;
    localparam logic [7:0] CMD_CONFIG_WRITE = 8'hd2;
    localparam logic [7:0] CMD_CHANNEL_CHOOSE = 8'hc3;
    localparam logic [7:0] CMD_POINTER_SELECT = 8'he1;
    localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
    localparam logic [7:0] CMD_LINE_BYTE_WRITE = 8'ha5;
    localparam logic [7:0] CMD_LINE_BYTE_READ = 8'h96;
    localparam logic [7:0] CMD_LINE_SINGLE_BIT = 8'h87;
    localparam logic [7:0] CMD_SEARCH_TRIPLET = 8'h78;
    // Channel choice value for the first line
    localparam logic [7:0] CHANNEL_ONE = 8'he1;
    // Read buffer geometry
    localparam int RD_AW = 3;
    localparam logic [3:0] RD_ONE = 4'h1;
    localparam logic [3:0] RD_ZERO = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_TX, ST_RX, ST_STOP
    } state_t;
    typedef enum logic [2:0] {
        SG_ADDR_W, SG_CMD, SG_PARAM, SG_ADDR_R, SG_READ
    } stage_t;

    // Known command code
    function automatic logic cmd_known(input logic [7:0] code);
        case (code)
            CMD_CHIP_RESET, CMD_CONFIG_WRITE, CMD_CHANNEL_CHOOSE,
            CMD_POINTER_SELECT, CMD_LINE_RESET, CMD_LINE_BYTE_WRITE,
            CMD_LINE_BYTE_READ, CMD_LINE_SINGLE_BIT,
            CMD_SEARCH_TRIPLET: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction

    // Command that the device expects one parameter byte after
    function automatic logic cmd_wants_param(input logic [7:0] code);
        case (code)
            CMD_CONFIG_WRITE, CMD_CHANNEL_CHOOSE, CMD_POINTER_SELECT,
            CMD_LINE_BYTE_WRITE, CMD_LINE_SINGLE_BIT,
            CMD_SEARCH_TRIPLET: cmd_wants_param = 1'b1;
            default: cmd_wants_param = 1'b0;
        endcase
    endfunction
endpackage

// Overview of operation
// - Bit timing selectable for 100 kbps or 400 kbps.
// - This host makes every clock pulse, START, STOP and byte count.
// - Bytes go most significant bit first, each followed by an ack slot.
// - Last address bit: 0 writes to device, 1 reads from it.
// - START is data falling while clock stays high.
// - STOP is data rising while clock stays high.
// - Repeated START joins write phase to read phase without STOP.
// - Data changes only with clock low; sampled while clock high.
// - Acknowledger holds data low through the ninth pulse; host pulses it.
// - After any missing ack the host ends with STOP first.
// - Host leaves the final read byte unacknowledged, then STOP.
// - Pointer select command precedes a read of another register.
// - Codes: chip reset f0, config write d2, channel choose c3.
// - Codes: pointer select e1, line reset b4, byte write a5.
// - Codes: byte read 96, single bit 87, search triplet 78.
// - On refused command code the host stops at once.
// - Channel value e1 selects the first line and is acknowledged.
module i2c_host_command_port #(
    parameter logic [3:0] ADDR_FIXED = 4'h3 // Arbitrary upper address bits
) (
    input wire logic sys_clk_in,            // 100 MHz system clock
    input wire logic resetn_in,             // Async reset, active low
    input wire logic clk_en_in,             // Freezes all state while low
    input wire logic std_mode_in,           // 1 selects 100 kbps timing
    input wire logic [2:0] addr_sel_in,     // Device address pin levels
    input wire logic cmd_valid_in,          // Request strobe
    input wire logic cmd_write_in,          // 1 sends a command first
    input wire logic [7:0] cmd_code_in,     // Command code
    input wire logic [7:0] cmd_param_in,    // Parameter byte
    input wire logic [3:0] rd_count_in,     // Bytes to read back
    input wire logic [2:0] rd_index_in,     // Read buffer index
    output logic cmd_ready_out,             // Idle and able to take
    output logic done_out,                  // Transaction finished pulse
    output logic reject_out,                // Unknown code refused pulse
    output logic nack_out,                  // Last transaction was refused
    output logic [2:0] nack_stage_out,      // Byte that was refused
    output logic [3:0] rd_got_out,          // Bytes stored last read
    output logic [7:0] rd_data_out,         // Buffered read byte
    input wire logic scl_in,                // Clock line level
    output logic scl_out,                   // Clock line drive value
    output logic scl_oe_out,                // Clock line pull low
    input wire logic sda_in,                // Data line level
    output logic sda_out,                   // Data line drive value
    output logic sda_oe_out                 // Data line pull low
);
    i2c_host_pkg::state_t state_reg;
    i2c_host_pkg::stage_t stage_reg;
    logic [8:0] qcnt_reg;
    logic [1:0] quarter_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_reg;
    logic [7:0] code_reg;
    logic [7:0] param_reg;
    logic has_param_reg;
    logic [3:0] rd_left_reg;
    logic [3:0] rd_cnt_reg;
    logic [2:0] sel_reg;
    logic std_reg;
    logic from_idle_reg;
    logic acked_reg;
    logic scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
    logic [8:0] qlimit;
    logic tick, adv, unit_end, sample;
    logic scl_low_c, sda_low_c, buf_wr;
    logic [7:0] addr_w_byte, addr_r_byte;

    // Address bytes built from fixed bits and the pin levels
    assign addr_w_byte = {ADDR_FIXED, sel_reg, i2c_host_pkg::DIR_WRITE};
    assign addr_r_byte = {ADDR_FIXED, sel_reg, i2c_host_pkg::DIR_READ};

    // Two-flop synchronisers for the bus lines
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
        end else if (clk_en_in) begin
            scl_m_reg <= scl_in;
            scl_s_reg <= scl_m_reg;
            sda_m_reg <= sda_in;
            sda_s_reg <= sda_m_reg;
        end
    end

    // Quarter-bit timer; a slow-rising clock line holds the high phase
    assign qlimit = std_reg ? i2c_host_pkg::QTR_STD_CYC
                            : i2c_host_pkg::QTR_FAST_CYC;
    assign tick = (qcnt_reg == qlimit - 9'h001);
    assign adv = tick && !(quarter_reg == i2c_host_pkg::Q_RISE && !scl_s_reg);
    assign unit_end = adv && quarter_reg == i2c_host_pkg::Q_LAST;
    assign sample = adv && quarter_reg == i2c_host_pkg::Q_RISE;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            qcnt_reg <= 9'h000;
            quarter_reg <= i2c_host_pkg::Q_FALL;
        end else if (clk_en_in) begin
            if (state_reg == i2c_host_pkg::ST_IDLE) begin
                qcnt_reg <= 9'h000;
                quarter_reg <= i2c_host_pkg::Q_FALL;
            end else if (tick) begin
                qcnt_reg <= 9'h000;
                if (adv) begin
                    quarter_reg <= quarter_reg + 2'h1;
                end
            end else begin
                qcnt_reg <= qcnt_reg + 9'h001;
            end
        end
    end

    // Line levels wanted in each quarter
    always_comb begin
        scl_low_c = 1'b0;
        sda_low_c = 1'b0;
        case (state_reg)
            i2c_host_pkg::ST_START: begin
                // Data drops while clock is high; lifts both first
                scl_low_c = !from_idle_reg && quarter_reg < i2c_host_pkg::Q_RISE;
                sda_low_c = quarter_reg == i2c_host_pkg::Q_LAST;
            end
            i2c_host_pkg::ST_TX: begin
                scl_low_c = quarter_reg < i2c_host_pkg::Q_RISE;
                // Ack slot released so the device can answer
                sda_low_c = bit_reg != i2c_host_pkg::ACK_SLOT
                            && !shift_reg[7];
            end
            i2c_host_pkg::ST_RX: begin
                scl_low_c = quarter_reg < i2c_host_pkg::Q_RISE;
                // Ack all but the last byte
                sda_low_c = bit_reg == i2c_host_pkg::ACK_SLOT
                            && rd_left_reg > i2c_host_pkg::RD_ONE;
            end
            i2c_host_pkg::ST_STOP: begin
                scl_low_c = quarter_reg < i2c_host_pkg::Q_RISE;
                sda_low_c = quarter_reg != i2c_host_pkg::Q_LAST;
            end
            default: begin
                scl_low_c = 1'b0;
                sda_low_c = 1'b0;
            end
        endcase
    end

    // Pin flops; data held on the falling quarter to keep hold time
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            scl_oe_out <= scl_low_c;
            if (!(quarter_reg == i2c_host_pkg::Q_FALL &&
                  state_reg != i2c_host_pkg::ST_IDLE)) begin
                sda_oe_out <= sda_low_c;
            end
        end
    end
    // Open-drain style: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // Read byte stored at the end of its ack slot
    assign buf_wr = unit_end && state_reg == i2c_host_pkg::ST_RX &&
                    bit_reg == i2c_host_pkg::ACK_SLOT;

    // Transaction sequencer
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= i2c_host_pkg::ST_IDLE;
            stage_reg <= i2c_host_pkg::SG_ADDR_W;
            bit_reg <= 4'h0;
            shift_reg <= 8'hff;
            rx_reg <= 8'h00;
            code_reg <= 8'h00;
            param_reg <= 8'h00;
            has_param_reg <= 1'b0;
            rd_left_reg <= 4'h0;
            sel_reg <= 3'h0;
            std_reg <= 1'b0;
            from_idle_reg <= 1'b1;
            acked_reg <= 1'b0;
        end else if (clk_en_in) begin
            case (state_reg)
                i2c_host_pkg::ST_IDLE: begin
                    if (cmd_valid_in && (!cmd_write_in ||
                        i2c_host_pkg::cmd_known(cmd_code_in))) begin
                        sel_reg <= addr_sel_in;
                        std_reg <= std_mode_in;
                        code_reg <= cmd_code_in;
                        param_reg <= cmd_param_in;
                        has_param_reg <=
                            i2c_host_pkg::cmd_wants_param(cmd_code_in);
                        // A bare read always fetches at least one byte
                        rd_left_reg <= (!cmd_write_in &&
                            rd_count_in == i2c_host_pkg::RD_ZERO) ?
                            i2c_host_pkg::RD_ONE : rd_count_in;
                        from_idle_reg <= 1'b1;
                        stage_reg <= cmd_write_in ? i2c_host_pkg::SG_ADDR_W
                                                  : i2c_host_pkg::SG_ADDR_R;
                        state_reg <= i2c_host_pkg::ST_START;
                    end
                end
                i2c_host_pkg::ST_START: begin
                    if (unit_end) begin
                        bit_reg <= 4'h0;
                        // Address byte loaded late so sel_reg has settled
                        shift_reg <= stage_reg == i2c_host_pkg::SG_ADDR_W ?
                                     addr_w_byte : addr_r_byte;
                        state_reg <= i2c_host_pkg::ST_TX;
                    end
                end
                i2c_host_pkg::ST_TX: begin
                    if (sample && bit_reg == i2c_host_pkg::ACK_SLOT) begin
                        acked_reg <= !sda_s_reg;
                    end
                    if (unit_end) begin
                        if (bit_reg != i2c_host_pkg::ACK_SLOT) begin
                            shift_reg <= {shift_reg[6:0], 1'b1};
                            bit_reg <= bit_reg + 4'h1;
                        end else if (!acked_reg) begin
                            // Refusal ends the frame at once
                            state_reg <= i2c_host_pkg::ST_STOP;
                        end else begin
                            bit_reg <= 4'h0;
                            case (stage_reg)
                                i2c_host_pkg::SG_ADDR_W: begin
                                    stage_reg <= i2c_host_pkg::SG_CMD;
                                    shift_reg <= code_reg;
                                end
                                i2c_host_pkg::SG_CMD: begin
                                    if (has_param_reg) begin
                                        stage_reg <= i2c_host_pkg::SG_PARAM;
                                        shift_reg <= param_reg;
                                    end else if (rd_left_reg !=
                                                 i2c_host_pkg::RD_ZERO) begin
                                        from_idle_reg <= 1'b0;
                                        stage_reg <= i2c_host_pkg::SG_ADDR_R;
                                        shift_reg <= addr_r_byte;
                                        state_reg <= i2c_host_pkg::ST_START;
                                    end else begin
                                        state_reg <= i2c_host_pkg::ST_STOP;
                                    end
                                end
                                i2c_host_pkg::SG_PARAM: begin
                                    if (rd_left_reg != i2c_host_pkg::RD_ZERO) begin
                                        from_idle_reg <= 1'b0;
                                        stage_reg <= i2c_host_pkg::SG_ADDR_R;
                                        shift_reg <= addr_r_byte;
                                        state_reg <= i2c_host_pkg::ST_START;
                                    end else begin
                                        state_reg <= i2c_host_pkg::ST_STOP;
                                    end
                                end
                                i2c_host_pkg::SG_ADDR_R: begin
                                    stage_reg <= i2c_host_pkg::SG_READ;
                                    state_reg <= i2c_host_pkg::ST_RX;
                                end
                                default: begin
                                    state_reg <= i2c_host_pkg::ST_STOP;
                                end
                            endcase
                        end
                    end
                end
                i2c_host_pkg::ST_RX: begin
                    if (sample && bit_reg != i2c_host_pkg::ACK_SLOT) begin
                        rx_reg <= {rx_reg[6:0], sda_s_reg};
                    end
                    if (unit_end) begin
                        if (bit_reg != i2c_host_pkg::ACK_SLOT) begin
                            bit_reg <= bit_reg + 4'h1;
                        end else begin
                            bit_reg <= 4'h0;
                            rd_left_reg <= rd_left_reg - 4'h1;
                            if (rd_left_reg <= i2c_host_pkg::RD_ONE) begin
                                state_reg <= i2c_host_pkg::ST_STOP;
                            end
                        end
                    end
                end
                i2c_host_pkg::ST_STOP: begin
                    if (unit_end) begin
                        state_reg <= i2c_host_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= i2c_host_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Status: pulses, refusal record and read count
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out <= 1'b0;
            reject_out <= 1'b0;
            nack_out <= 1'b0;
            nack_stage_out <= 3'h0;
            rd_cnt_reg <= 4'h0;
        end else if (clk_en_in) begin
            done_out <= unit_end && state_reg == i2c_host_pkg::ST_STOP;
            reject_out <= state_reg == i2c_host_pkg::ST_IDLE &&
                cmd_valid_in && cmd_write_in &&
                !i2c_host_pkg::cmd_known(cmd_code_in);
            if (state_reg == i2c_host_pkg::ST_IDLE && cmd_valid_in) begin
                nack_out <= 1'b0;
                rd_cnt_reg <= 4'h0;
            end else if (unit_end && state_reg == i2c_host_pkg::ST_TX &&
                         bit_reg == i2c_host_pkg::ACK_SLOT && !acked_reg) begin
                nack_out <= 1'b1;
                nack_stage_out <= 3'(stage_reg);
            end
            if (buf_wr) begin
                rd_cnt_reg <= rd_cnt_reg + 4'h1;
            end
        end
    end
    assign rd_got_out = rd_cnt_reg;
    // Ready only while idle; bursts must wait for done
    assign cmd_ready_out = state_reg == i2c_host_pkg::ST_IDLE;

    // Read bytes kept for the user; wraps past eight
    host_read_buffer #(
        .DATA_W(8),
        .ADDR_W(i2c_host_pkg::RD_AW)
    ) u_rd_buf (
        .clk_in(sys_clk_in),
        .clk_en_in(clk_en_in),
        .wr_en_in(buf_wr),
        .wr_addr_in(rd_cnt_reg[2:0]),
        .wr_data_in(rx_reg),
        .rd_addr_in(rd_index_in),
        .rd_data_out(rd_data_out)
    );
endmodule

`default_nettype wire

// [verif/i2c_dev_model.sv]
`default_nettype none
module i2c_dev_model #(
    parameter logic [3:0] ADDR_FIXED = 4'h3
) (
    input wire logic scl_in, // Clock line
    input wire logic sda_in, // Data line
    input wire logic [2:0] pins_in, // Address pins
    input wire logic busy_in, // Line engine busy
    output logic sda_oe_out // Pulls data only, never clock
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh, cmd, ptr = 8'he1;
    int n = 0, st = 5, nx = 5;
    initial sda_oe_out = 1'b0;
    // START or repeated START opens a new address byte
    always @(negedge sda_in) if (scl_in) begin
        n = 0;
        st = 0;
        sda_oe_out = 1'b0;
    end
    always @(posedge sda_in) if (scl_in) st = 5;
    // Bits are taken on the rising clock
    always @(posedge scl_in) if (st < 5) begin
        if (n < 8) sh = {sh[6:0], sda_in};
        else if (st == 4) nx = sda_in ? 5 : 4;
        n++;
    end
    // Ack held from one falling edge to the next; refusal leaves it high
    always @(negedge scl_in) if (st < 5) begin
        if (n == 9) begin
            n = 0;
            st = nx;
            sda_oe_out = 1'b0;
        end else if (n == 8) begin
            case (st)
            0: sda_oe_out = sh[7:1] == {ADDR_FIXED, pins_in};
            1: sda_oe_out = !busy_in && sh inside {8'hf0, 8'hd2, 8'hc3,
                8'he1, 8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78};
            2: sda_oe_out = cmd inside {8'hd2, 8'hc3, 8'he1, 8'ha5, 8'h87,
                8'h78} && sh != 8'he5;
            default: sda_oe_out = 1'b0;
            endcase
            if (st < 4) nx = !sda_oe_out ? 5 : (st == 0 && sh[0]) ? 4 : st + 1;
            if (st == 1) cmd = sh;
            if (st == 2 && sda_oe_out && cmd == 8'he1) ptr = sh;
        end
        if (st == 4 && n < 8)
            sda_oe_out = !((ptr ^ 8'h17) >> (7 - n) & 1);
    end
endmodule
`default_nettype wire

// [verif/i2c_host_command_port_asserts.sv]
`default_nettype none
module i2c_host_command_port_asserts (
    input wire logic sys_clk_in, // Clock
    input wire logic resetn_in, // Reset
    input wire logic clk_en_in, // Run
    input wire logic cmd_valid_in, // Request
    input wire logic cmd_write_in, // Write
    input wire logic [7:0] cmd_code_in, // Code
    input wire logic cmd_ready_out, // Idle
    input wire logic done_out, // End
    input wire logic reject_out, // Refused
    input wire logic scl_out, // Clock value
    input wire logic scl_oe_out, // Clock low
    input wire logic sda_out, // Data value
    input wire logic sda_oe_out // Data low
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    logic known;
    // Unknown codes must never reach the bus
    assign known = cmd_code_in inside {8'hf0, 8'hd2, 8'hc3, 8'he1,
        8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78};
    sequence s_take;
        cmd_valid_in && cmd_ready_out && cmd_write_in && clk_en_in;
    endsequence
    sequence s_start;
        $rose(sda_oe_out) && !scl_oe_out;
    endsequence
    sequence s_stop;
        $fell(sda_oe_out) && !scl_oe_out;
    endsequence
    AST_UNKNOWN:
        assert property (s_take ##0 !known |=> reject_out)
        else $error("unknown code not rejected");
    AST_KNOWN:
        assert property (s_take ##0 known |=> !cmd_ready_out && !reject_out)
        else $error("known code not started");
    AST_START:
        assert property (s_start |-> ##[1:600] scl_oe_out)
        else $error("start not followed by clock");
    AST_STOP:
        assert property (s_stop |-> ##[1:600] done_out)
        else $error("stop not followed by done");
    AST_DONE:
        assert property (done_out |-> cmd_ready_out ##1 !done_out)
        else $error("done not a single pulse");
    AST_IDLE:
        assert property (cmd_ready_out |-> !scl_oe_out && !sda_oe_out)
        else $error("lines held while idle");
    AST_DRAIN:
        assert property (!scl_out && !sda_out)
        else $error("line driven high");
    AST_LOWHOLD:
        assert property ($rose(scl_oe_out) |=> scl_oe_out [*8])
        else $error("clock low phase too short");
endmodule
bind i2c_host_command_port i2c_host_command_port_asserts chk (
    .sys_clk_in, .resetn_in, .clk_en_in, .cmd_valid_in, .cmd_write_in,
    .cmd_code_in, .cmd_ready_out, .done_out, .reject_out, .scl_out,
    .scl_oe_out, .sda_out, .sda_oe_out
);
`default_nettype wire

// [verif/i2c_host_command_port_tb.sv]
`default_nettype none
module i2c_host_command_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0, resetn = 1'b0, std_mode = 1'b0, valid = 1'b0;
    logic wr = 1'b0, busy = 1'b0, rej_seen, ready, done, rej, nack;
    logic scl_oe, sda_oe, dev_oe;
    logic [2:0] pins = 3'h5, rd_index = 3'h0, stg;
    logic [7:0] code = 8'h00, param = 8'h00, rdat;
    logic [3:0] rd_count = 4'h0, got;
    wire scl, sda;
    int n_mismatch = 0, n_tests = 0;
    // Pull-ups: a line is low only while someone pulls it
    assign scl = !scl_oe;
    assign sda = !(sda_oe || dev_oe);
    always #5 sys_clk = ~sys_clk;
    i2c_host_command_port uut (.sys_clk_in(sys_clk), .resetn_in(resetn),
        .clk_en_in(1'b1), .std_mode_in(std_mode), .addr_sel_in(pins),
        .cmd_valid_in(valid), .cmd_write_in(wr), .cmd_code_in(code),
        .cmd_param_in(param), .rd_count_in(rd_count), .rd_index_in(rd_index),
        .cmd_ready_out(ready), .done_out(done), .reject_out(rej),
        .nack_out(nack), .nack_stage_out(stg), .rd_got_out(got),
        .rd_data_out(rdat), .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
        .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe));
    i2c_dev_model dev (.scl_in(scl), .sda_in(sda), .pins_in(3'h5),
        .busy_in(busy), .sda_oe_out(dev_oe));
    task automatic check(input string what, input logic [7:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One request, then wait for its end under a bound
    task automatic run(input logic w, input logic [7:0] c, p,
            input logic [3:0] rn, input logic sm);
        int k = 0;
        @(posedge sys_clk);
        wr <= w;
        code <= c;
        param <= p;
        rd_count <= rn;
        std_mode <= sm;
        valid <= 1'b1;
        @(posedge sys_clk);
        valid <= 1'b0;
        rej_seen = 1'b0;
        do begin
            @(negedge sys_clk);
            rej_seen |= rej === 1'b1;
            k++;
        end while (k < 30000 && done !== 1'b1 && !rej_seen);
        check("finish", {7'h0, done === 1'b1 || rej_seen}, 8'h01);
    endtask
    task automatic peek(input logic [2:0] i, input logic [7:0] e);
        @(posedge sys_clk);
        rd_index <= i;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("rdata", rdat, e);
    endtask
    // Every code acked, with a parameter only where one is due
    task automatic t_codes();
        logic [7:0] cs [9] = '{8'hf0, 8'hd2, 8'hc3, 8'he1, 8'hb4, 8'ha5,
            8'h96, 8'h87, 8'h78};
        foreach (cs[i]) begin
            run(1'b1, cs[i], 8'he1, 4'h0, 1'b0);
            check("code nack", {7'h0, nack}, 8'h00);
        end
    endtask
    // Refusals: unknown code, busy engine, bad parameter, other address
    task automatic t_refuse();
        run(1'b1, 8'h11, 8'h00, 4'h0, 1'b0);
        check("reject", {7'h0, rej_seen}, 8'h01);
        busy = 1'b1;
        run(1'b1, 8'hc3, 8'he1, 4'h0, 1'b0);
        check("busy stage", {4'h0, nack, stg}, 8'h09);
        busy = 1'b0;
        run(1'b1, 8'hc3, 8'he5, 4'h0, 1'b0);
        check("param stage", {4'h0, nack, stg}, 8'h0a);
        @(posedge sys_clk) pins <= 3'h2;
        run(1'b1, 8'hf0, 8'h00, 4'h0, 1'b1);
        check("addr stage", {4'h0, nack, stg}, 8'h08);
        @(posedge sys_clk) pins <= 3'h5;
    endtask
    // Pointer change, repeated START read, then a plain read
    task automatic t_read();
        run(1'b1, 8'he1, 8'hc3, 4'h3, 1'b0);
        check("got", {4'h0, got}, 8'h03);
        for (int i = 0; i < 3; i++)
            peek(3'(i), 8'hd4);
        run(1'b0, 8'h00, 8'h00, 4'h0, 1'b0);
        check("got one", {4'h0, got}, 8'h01);
        peek(3'h0, 8'hd4);
    endtask
    initial begin
        #2_000_000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        check("ready", {7'h0, ready}, 8'h01);
        resetn <= 1'b1;
        t_codes();
        t_refuse();
        t_read();
        end_sim();
    end
endmodule
`default_nettype wire
